// ---- design/dsp_cfg.svh ----
// constants of the divider setting planner: register map, limits and timing
// Functional notes
// - minimum total division is lowest VCO frequency over requested output frequency
// - low-speed divider takes the smallest power of two that leaves a legal high-speed divider
// - high-speed divider is nearest legal integer reaching minimum VCO, stepping upward only
// - odd high-speed values above 33 are illegal; step up to next even
// - VCO target is output times both dividers and must fit the grade range
// - feedback divider is VCO target over crystal frequency, control voltage centred
// - feedback divider is 43-bit unsigned, 11 integer bits and 32 fraction bits
// - fraction is fractional part times two to the 32, truncated
// - low-speed divider as 3-bit exponent, high-speed as 11-bit binary value
// - gain must be recalibrated whenever VCO differs from factory default
// - feedback integer part is truncated before choosing the ADC-rate divider
// - ADC-rate divider 16 to 71, 18 to 78, 20 to 85, else 22
// - gain scale is round of 128 times 80e6 over VCO/adc divider/8
// - high-speed divider 4 to 2046; odd only up to 33
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DSP_OFS_CTRL      8'h00
`define DSP_OFS_FOUT      8'h04
`define DSP_OFS_STATUS    8'h08
`define DSP_OFS_HS_LS     8'h0c
`define DSP_OFS_FB_FRAC   8'h10
`define DSP_OFS_FB_INT    8'h14
`define DSP_OFS_ADC_GAIN  8'h18
`define DSP_OFS_FVCO_LO   8'h1c
`define DSP_OFS_FVCO_HI   8'h20
`define DSP_OFS_FACT_LO   8'h24
`define DSP_OFS_FACT_HI   8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DSP_CTRL_START    0
`define DSP_CTRL_GRADE_LO 1
`define DSP_ST_BUSY       0
`define DSP_ST_DONE       1
`define DSP_ST_ERROR      2
`define DSP_ST_RECAL      3
`define DSP_LS_POS        16
`define DSP_GAIN_POS      8

// ----------------------------------------------------------------
// reset values and frequency limits in Hz
// ----------------------------------------------------------------
`define DSP_FOUT_RST      32'h0957_b9b0
`define DSP_FACT_RST      48'h0000_0000_0000
`define DSP_FVCO_MIN      48'd10800000000
`define DSP_FVCO_MAX_A    48'd13122222022
`define DSP_FVCO_MAX_B    48'd12511886114
`define DSP_FVCO_MAX_C    48'd12206718160
`define DSP_FXTAL         48'd152600000
`define DSP_ADC_NOM_X1024 48'd81920000000
`define DSP_HS_MIN        40'd4
`define DSP_HS_ODD_MAX    40'd33
`define DSP_HS_MAX        40'd2046
`define DSP_LS_MAX        3'd5
`define DSP_FBI_18        11'd72
`define DSP_FBI_20        11'd79
`define DSP_FBI_22        11'd86
`define DSP_DIV_STEPS     7'd72

`endif

// ---- design/dsp_pkg.sv ----
// types shared by the divider setting planner
package dsp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DIV    = 3'b001,
        ST_PICK   = 3'b010,
        ST_FB     = 3'b011,
        ST_GAIN   = 3'b100,
        ST_FINISH = 3'b101
    } dsp_state_t;

    typedef struct packed {
        logic [2:0]  ls_code;
        logic [10:0] hs_div;
        logic [42:0] fb_div;
        logic [4:0]  adc_div;
        logic [7:0]  gain;
        logic [47:0] fvco;
    } dsp_plan_t;

endpackage

// ---- design/dsp_top.sv ----
// divider setting planner: apb register front end and serial planning engine
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "dsp_cfg.svh"

module dsp_top
    import dsp_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // plan result
    output dsp_plan_t        PLAN_O,
    output logic             PLAN_VALID_O,
    output logic             PLAN_ERROR_O,
    output logic             RECAL_NEEDED_O
);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic [31:0] rd_mux;

    assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign mapped   = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `DSP_OFS_FACT_HI);
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dsp_state_t  state_q;
    dsp_state_t  ret_q;
    dsp_plan_t   plan_q;
    logic [31:0] fout_q;
    logic [1:0]  grade_q;
    logic [47:0] fact_q;
    logic        busy_q;
    logic        done_q;
    logic        err_q;
    logic [39:0] min_q;
    logic [2:0]  k_q;
    logic [71:0] num_q;
    logic [47:0] den_q;
    logic [48:0] rem_q;
    logic [71:0] quo_q;
    logic [6:0]  cnt_q;
    logic        start;

    assign start = wr_en && (PADDR_I == `DSP_OFS_CTRL) && PWDATA_I[`DSP_CTRL_START] && !busy_q;

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // a register write that lands while busy is dropped so the engine sees stable inputs
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fout_q  <= `DSP_FOUT_RST;
            grade_q <= 2'h0;
            fact_q  <= `DSP_FACT_RST;
        end else if (wr_en && !busy_q) begin
            case (PADDR_I)
                `DSP_OFS_CTRL:    grade_q <= PWDATA_I[`DSP_CTRL_GRADE_LO +: 2];
                `DSP_OFS_FOUT:    fout_q <= PWDATA_I;
                `DSP_OFS_FACT_LO: fact_q[31:0] <= PWDATA_I;
                `DSP_OFS_FACT_HI: fact_q[47:32] <= PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // combinational search step
    // ----------------------------------------------------------------
    logic [39:0] hs_raw;
    logic [39:0] hs_leg;
    logic [47:0] fvco_c;
    logic [47:0] fvco_max;
    logic [48:0] rem_sh;
    logic        rem_ge;
    logic [10:0] fb_int;
    logic [4:0]  adc_c;

    always_comb begin
        hs_raw = (min_q + ((40'h1 << k_q) - 40'h1)) >> k_q;
        if (hs_raw < `DSP_HS_MIN) begin
            hs_leg = `DSP_HS_MIN;
        end else if (hs_raw > `DSP_HS_ODD_MAX && hs_raw[0]) begin
            hs_leg = hs_raw + 40'h1;
        end else begin
            hs_leg = hs_raw;
        end
    end

    assign fvco_c = (48'(fout_q) * 48'(hs_leg[10:0])) << k_q;

    always_comb begin
        case (grade_q)
            2'h0:    fvco_max = `DSP_FVCO_MAX_A;
            2'h1:    fvco_max = `DSP_FVCO_MAX_B;
            default: fvco_max = `DSP_FVCO_MAX_C;
        endcase
    end

    assign rem_sh = {rem_q[47:0], num_q[71]};
    assign rem_ge = rem_sh >= {1'b0, den_q};
    assign fb_int = quo_q[42:32];

    always_comb begin
        if (fb_int >= `DSP_FBI_22) begin
            adc_c = 5'd22;
        end else if (fb_int >= `DSP_FBI_20) begin
            adc_c = 5'd20;
        end else if (fb_int >= `DSP_FBI_18) begin
            adc_c = 5'd18;
        end else begin
            adc_c = 5'd16;
        end
    end

    // ----------------------------------------------------------------
    // planning engine
    // ----------------------------------------------------------------
    // one shared restoring divider serves all three quotients; 72 steps each
    // trades latency (about 220 cycles a plan) for a single subtractor
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= ST_IDLE;
            ret_q   <= ST_IDLE;
            min_q   <= 40'h0;
            k_q     <= 3'h0;
            num_q   <= 72'h0;
            den_q   <= 48'h0;
            rem_q   <= 49'h0;
            quo_q   <= 72'h0;
            cnt_q   <= 7'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start && fout_q != 32'h0) begin
                        num_q   <= 72'(`DSP_FVCO_MIN) + 72'(fout_q) - 72'h1;
                        den_q   <= 48'(fout_q);
                        rem_q   <= 49'h0;
                        cnt_q   <= `DSP_DIV_STEPS;
                        ret_q   <= ST_PICK;
                        k_q     <= 3'h0;
                        state_q <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    num_q <= {num_q[70:0], 1'b0};
                    rem_q <= rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
                    quo_q <= {quo_q[70:0], rem_ge};
                    cnt_q <= cnt_q - 7'h1;
                    if (cnt_q == 7'h1) begin
                        state_q <= ret_q;
                    end
                end
                ST_PICK: begin
                    if (ret_q == ST_PICK) begin
                        min_q <= quo_q[39:0];
                        ret_q <= ST_FB;
                    end else if (hs_leg > `DSP_HS_MAX) begin
                        if (k_q == `DSP_LS_MAX) begin
                            state_q <= ST_FINISH;
                        end else begin
                            k_q <= k_q + 3'h1;
                        end
                    end else if (fvco_c > fvco_max || fvco_c < `DSP_FVCO_MIN) begin
                        state_q <= ST_FINISH;
                    end else begin
                        num_q   <= {fvco_c[39:0], 32'h0};
                        den_q   <= `DSP_FXTAL;
                        rem_q   <= 49'h0;
                        cnt_q   <= `DSP_DIV_STEPS;
                        state_q <= ST_DIV;
                    end
                end
                ST_FB: begin
                    // rounding: (2n + d) / 2d
                    num_q   <= 72'(`DSP_ADC_NOM_X1024 * 48'(adc_c)) * 72'h2
                               + 72'(plan_q.fvco);
                    den_q   <= {plan_q.fvco[46:0], 1'b0};
                    rem_q   <= 49'h0;
                    cnt_q   <= `DSP_DIV_STEPS;
                    ret_q   <= ST_GAIN;
                    state_q <= ST_DIV;
                end
                ST_GAIN: begin
                    state_q <= ST_FINISH;
                end
                ST_FINISH: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // plan result
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            plan_q <= '0;
        end else if (state_q == ST_PICK && ret_q == ST_FB && hs_leg <= `DSP_HS_MAX) begin
            plan_q.ls_code <= k_q;
            plan_q.hs_div  <= hs_leg[10:0];
            plan_q.fvco    <= fvco_c;
        end else if (state_q == ST_FB) begin
            plan_q.fb_div  <= quo_q[42:0];
            plan_q.adc_div <= adc_c;
        end else if (state_q == ST_GAIN) begin
            plan_q.gain <= quo_q[7:0];
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // the zero-frequency request fails at once rather than dividing by zero
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end else if (start) begin
            busy_q <= fout_q != 32'h0;
            done_q <= fout_q == 32'h0;
            err_q  <= fout_q == 32'h0;
        end else if (state_q == ST_FINISH) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            err_q  <= ret_q != ST_GAIN;
        end
    end

    assign PLAN_O         = plan_q;
    assign PLAN_VALID_O   = done_q & ~err_q;
    assign PLAN_ERROR_O   = err_q;
    assign RECAL_NEEDED_O = done_q & ~err_q & (plan_q.fvco != fact_q);

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        case (PADDR_I)
            `DSP_OFS_CTRL:     rd_mux = {29'h0, grade_q, 1'b0};
            `DSP_OFS_FOUT:     rd_mux = fout_q;
            `DSP_OFS_STATUS:   rd_mux = {28'h0, RECAL_NEEDED_O, err_q, done_q, busy_q};
            `DSP_OFS_HS_LS:    rd_mux = {13'h0, plan_q.ls_code, 5'h0, plan_q.hs_div};
            `DSP_OFS_FB_FRAC:  rd_mux = plan_q.fb_div[31:0];
            `DSP_OFS_FB_INT:   rd_mux = {21'h0, plan_q.fb_div[42:32]};
            `DSP_OFS_ADC_GAIN: rd_mux = {16'h0, plan_q.gain, 3'h0, plan_q.adc_div};
            `DSP_OFS_FVCO_LO:  rd_mux = plan_q.fvco[31:0];
            `DSP_OFS_FVCO_HI:  rd_mux = {16'h0, plan_q.fvco[47:32]};
            `DSP_OFS_FACT_LO:  rd_mux = fact_q[31:0];
            `DSP_OFS_FACT_HI:  rd_mux = {16'h0, fact_q[47:32]};
            default:           rd_mux = 32'h0;
        endcase
    end

    // read data is caught in the setup cycle so it leaves a flip-flop
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= 32'h0;
        end else if (rd_setup) begin
            PRDATA_O <= rd_mux;
        end
    end

endmodule

// ---- testbench/dsp_top_checker.sv ----
// port assertions of the divider setting planner
`timescale 1ns/1ns
`include "dsp_cfg.svh"
module dsp_top_checker
    import dsp_pkg::*;
(
    // clock, reset and apb
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PSLVERR_O,
    // plan result
    input wire dsp_plan_t   PLAN_O,
    input wire logic        PLAN_VALID_O,
    input wire logic        PLAN_ERROR_O,
    input wire logic        RECAL_NEEDED_O
);
    logic [95:0] fb_prod;
    logic [10:0] fbi;
    logic        start_wr;
    logic [31:0] fout_sh;
    logic        busy_sh;
    // fb times crystal rebuilds fvco, short by at most the dropped fraction
    assign fb_prod  = {53'h0, PLAN_O.fb_div} * 96'd152600000;
    assign fbi      = PLAN_O.fb_div[42:32];
    assign start_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h00 && PWDATA_I[0];
    // shadow of the requested frequency; writes while a plan runs are dropped
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fout_sh <= `DSP_FOUT_RST;
        end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h04 && !busy_sh) begin
            fout_sh <= PWDATA_I;
        end
    end
    // a zero request finishes at once, so it never counts as busy
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_sh <= 1'b0;
        end else if (start_wr && !busy_sh) begin
            busy_sh <= fout_sh != 32'h0;
        end else if (PLAN_VALID_O || PLAN_ERROR_O) begin
            busy_sh <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_hs_legal: assert property (PLAN_VALID_O |-> PLAN_O.hs_div >= 11'd4 &&
        PLAN_O.hs_div <= 11'd2046 && (PLAN_O.hs_div <= 11'd33 || !PLAN_O.hs_div[0]))
        else $error("illegal high speed divider");
    a_ls_min: assert property (PLAN_VALID_O |-> PLAN_O.ls_code <= 3'd5 &&
        (PLAN_O.ls_code == 3'd0 || PLAN_O.hs_div >= 11'd1023))
        else $error("low speed divider not minimal");
    a_adc_table: assert property (PLAN_VALID_O |-> PLAN_O.adc_div ==
        (fbi < 11'd72 ? 5'd16 : fbi < 11'd79 ? 5'd18 : fbi < 11'd86 ? 5'd20 : 5'd22))
        else $error("adc rate divider off table");
    a_fvco_range: assert property (PLAN_VALID_O |-> PLAN_O.fvco >= `DSP_FVCO_MIN &&
        PLAN_O.fvco <= `DSP_FVCO_MAX_A) else $error("vco target out of range");
    a_fvco_fb: assert property (PLAN_VALID_O |-> fb_prod[79:32] <= PLAN_O.fvco &&
        fb_prod[79:32] + 48'd2 >= PLAN_O.fvco) else $error("feedback divider mismatch");
    a_recal_valid: assert property (RECAL_NEEDED_O |-> PLAN_VALID_O)
        else $error("recal flagged without plan");
    a_valid_err: assert property (PLAN_VALID_O |-> !PLAN_ERROR_O)
        else $error("valid and error together");
    a_plan_hold: assert property (PLAN_VALID_O && $past(PLAN_VALID_O) |-> $stable(PLAN_O))
        else $error("plan changed while valid");
    a_start_clr: assert property (start_wr && PLAN_VALID_O |=> !PLAN_VALID_O &&
        PLAN_ERROR_O == (fout_sh == 32'h0)) else $error("start did not clear result");
    a_slverr_map: assert property (PSEL_I && PENABLE_I |->
        PSLVERR_O == (PADDR_I > 8'h28 || PADDR_I[1:0] != 2'b00))
        else $error("slave error decode wrong");
endmodule
bind dsp_top dsp_top_checker i_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSLVERR_O(PSLVERR_O), .PLAN_O(PLAN_O), .PLAN_VALID_O(PLAN_VALID_O),
    .PLAN_ERROR_O(PLAN_ERROR_O), .RECAL_NEEDED_O(RECAL_NEEDED_O));

// ---- testbench/dsp_osc_model.sv ----
// behavioural oscillator that turns a plan back into an output frequency
`timescale 1ns/1ns
`include "dsp_cfg.svh"
module dsp_osc_model
    import dsp_pkg::*;
(
    // settings and speed grade
    input  wire dsp_plan_t   plan_i,
    input  wire logic [1:0]  grade_i,
    // synthesised result
    output logic      [47:0] fout_o,
    output logic             in_range_o
);
    logic [95:0] prod;
    logic [47:0] fvco;
    logic [47:0] fmax;
    logic [15:0] ratio;
    always_comb begin
        prod = {53'h0, plan_i.fb_div} * 96'd152600000;
        fvco = prod[79:32];
        // codes above 5 still divide by 32
        ratio = 16'(plan_i.hs_div) << ((plan_i.ls_code > 3'd5) ? 3'd5 : plan_i.ls_code);
        fout_o = (ratio == 16'h0) ? 48'h0 : fvco / 48'(ratio);
        case (grade_i)
            2'd0: fmax = `DSP_FVCO_MAX_A;
            2'd1: fmax = `DSP_FVCO_MAX_B;
            default: fmax = `DSP_FVCO_MAX_C;
        endcase
        // slack of 2 Hz covers the truncated fraction
        in_range_o = fvco + 48'd2 >= `DSP_FVCO_MIN && fvco <= fmax;
    end
endmodule

// ---- testbench/dsp_top_bench.sv ----
// self-checking bench of the divider setting planner
`timescale 1ns/1ns
`include "dsp_cfg.svh"
module dsp_top_bench
    import dsp_pkg::*;
;
    typedef struct {
        logic [31:0] f;
        logic [1:0]  g;
        logic        e;
        logic [10:0] hs;
        logic [2:0]  ls;
        logic [10:0] fbi;
        logic [4:0]  adc;
        logic [7:0]  gain;
        logic [47:0] fvco;
    } dsp_case_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dsp_plan_t   plan;
    logic        plan_valid;
    logic        plan_error;
    logic        recal;
    logic [47:0] m_fout;
    logic        m_ok;
    logic [31:0] rq;
    logic        re;
    int          error_cnt = 0;
    int          n_checks = 0;
    dsp_case_t   tbl [6] = '{
        '{32'd156750000, 2'd3, 1'b0, 11'd70, 3'd0, 11'd71, 5'd16, 8'd119, 48'd10972500000},
        '{32'd3000000000, 2'd1, 1'b0, 11'd4, 3'd0, 11'd78, 5'd18, 8'd123, 48'd12000000000},
        '{32'd2500000000, 2'd2, 1'b1, 11'd0, 3'd0, 11'd0, 5'd0, 8'd0, 48'd0},
        '{32'd2500000000, 2'd0, 1'b0, 11'd5, 3'd0, 11'd81, 5'd20, 8'd131, 48'd12500000000},
        '{32'd1000000, 2'd1, 1'b0, 11'd1350, 3'd3, 11'd70, 5'd16, 8'd121, 48'd10800000000},
        '{32'd0, 2'd0, 1'b1, 11'd0, 3'd0, 11'd0, 5'd0, 8'd0, 48'd0}};
    always #4 clk = ~clk;
    dsp_top i_dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PLAN_O(plan), .PLAN_VALID_O(plan_valid),
        .PLAN_ERROR_O(plan_error), .RECAL_NEEDED_O(recal));
    // model checks against the fastest grade
    dsp_osc_model i_osc (.plan_i(plan), .grade_i(2'd0), .fout_o(m_fout), .in_range_o(m_ok));
    task automatic results;
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the leading edge keeps an idle cycle between transfers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done;
        apb(1'b0, 8'h08, 32'h0);
        for (int i = 0; i < 400 && rq[1] !== 1'b1; i++) apb(1'b0, 8'h08, 32'h0);
    endtask
    task automatic t_reset;
        apb(1'b0, 8'h04, 32'h0);
        chk(rq, `DSP_FOUT_RST);
        apb(1'b0, 8'h08, 32'h0);
        chk(rq, 32'h0);
        chk({plan_valid, plan_error, recal}, 3'b000);
        chk(pready, 1'b1);
        apb(1'b1, 8'h2c, 32'h1);
        chk(re, 1'b1);
        apb(1'b0, 8'h2c, 32'h0);
        chk({re, rq}, {1'b1, 32'h0});
        apb(1'b0, 8'h05, 32'h0);
        chk(re, 1'b1);
    endtask
    task automatic t_case(input dsp_case_t c);
        apb(1'b1, 8'h04, c.f);
        apb(1'b1, 8'h00, {29'h0, c.g, 1'b1});
        wait_done();
        chk(rq[2:0], {c.e, 2'b10});
        chk(plan_valid, !c.e);
        chk(plan_error, c.e);
        if (!c.e) begin
            apb(1'b0, 8'h0c, 32'h0);
            chk(rq, {13'h0, c.ls, 5'h0, c.hs});
            apb(1'b0, 8'h14, 32'h0);
            chk(rq, {21'h0, c.fbi});
            apb(1'b0, 8'h18, 32'h0);
            chk(rq, {16'h0, c.gain, 3'h0, c.adc});
            apb(1'b0, 8'h1c, 32'h0);
            chk(rq, c.fvco[31:0]);
            apb(1'b0, 8'h20, 32'h0);
            chk(rq, {16'h0, c.fvco[47:32]});
            chk(recal, 1'b1);
            chk(m_ok, 1'b1);
            chk(m_fout + 48'd1 >= c.f && m_fout <= c.f, 1'b1);
        end
    endtask
    // writes during a run are dropped; then factory fvco clears recal
    task automatic t_busy;
        apb(1'b1, 8'h04, 32'd156750000);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'd1000000);
        apb(1'b1, 8'h00, 32'h7);
        apb(1'b0, 8'h08, 32'h0);
        chk(rq[0], 1'b1);
        wait_done();
        apb(1'b0, 8'h04, 32'h0);
        chk(rq, 32'd156750000);
        apb(1'b0, 8'h10, 32'h0);
        chk(rq, 32'he756e62a);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h24, 32'h8e03_1020);
        apb(1'b1, 8'h28, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk(rq[3:0], 4'b0010);
        chk(recal, 1'b0);
    endtask
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        for (int i = 0; i < 6; i++) t_case(tbl[i]);
        t_busy();
        results();
    end
endmodule
